/* hw/bvs_map.svh */
`ifndef BVS_MAP_SVH
`define BVS_MAP_SVH

// ==========================================================
// command and field layout
`define BVS_CMD_CODE      8'hD5
`define BVS_WR_MASK       16'hC01F
`define BVS_RSVD_MASK     16'h3FE0
`define BVS_SPARE_HI      15
`define BVS_SPARE_LO      14
`define BVS_CODE_HI       4
`define BVS_CODE_LO       0
`define BVS_WORD_RST      16'h0000

// ==========================================================
// timing: one ramp step of one dac lsb per slew period
`define BVS_CLK_NS        10
`define BVS_SLEW_STEP_NS  1000
`define BVS_SLEW_CYC      (`BVS_SLEW_STEP_NS / `BVS_CLK_NS)

// ==========================================================
// scaling: loop gain is q2.6, 64 means unity
`define BVS_GAIN_SHIFT    6

`endif

/* hw/bvs_pkg.sv */
package bvs_pkg;

  // ========================================================
  // carriers
  typedef struct packed {
    logic        write;
    logic [7:0]  code;
    logic [15:0] wdata;
  } bvs_req_s;

  typedef struct packed {
    logic        valid;
    logic        nack;
    logic [15:0] rdata;
  } bvs_resp_s;

  typedef enum logic [1:0] {MRG_NONE, MRG_HIGH, MRG_LOW} bvs_margin_e;

  typedef logic [10:0] bvs_dac_t;

endpackage : bvs_pkg

/* hw/bvs_boot_dac.sv */
`timescale 1ns/1ns
`include "bvs_map.svh"

module bvs_boot_dac
  import bvs_pkg::*;
(
  input  wire logic     clk,
  input  wire logic     sys_rst,
  input  wire logic [4:0] code,
  input  wire logic     ramp_en,
  output bvs_dac_t      target,
  output bvs_dac_t      ramp
);

  // ========================================================
  // code to dac voltage, lsb is 1/2048 v
  function automatic bvs_dac_t bvs_lut(input logic [4:0] c);
    case (c)
      5'h00:   bvs_lut = 11'h000;
      5'h01:   bvs_lut = 11'h266;
      5'h02:   bvs_lut = 11'h280;
      5'h03:   bvs_lut = 11'h29A;
      5'h04:   bvs_lut = 11'h2B4;
      5'h05:   bvs_lut = 11'h2CD;
      5'h06:   bvs_lut = 11'h2E6;
      5'h07:   bvs_lut = 11'h300;
      5'h08:   bvs_lut = 11'h31A;
      5'h09:   bvs_lut = 11'h333;
      5'h0A:   bvs_lut = 11'h34D;
      5'h0B:   bvs_lut = 11'h366;
      5'h0C:   bvs_lut = 11'h380;
      5'h0D:   bvs_lut = 11'h39A;
      5'h0E:   bvs_lut = 11'h3B4;
      5'h0F:   bvs_lut = 11'h3CD;
      5'h10:   bvs_lut = 11'h3E6;
      5'h11:   bvs_lut = 11'h400;
      5'h12:   bvs_lut = 11'h41A;
      5'h13:   bvs_lut = 11'h433;
      5'h14:   bvs_lut = 11'h44C;
      5'h15:   bvs_lut = 11'h466;
      5'h16:   bvs_lut = 11'h480;
      5'h17:   bvs_lut = 11'h49A;
      5'h18:   bvs_lut = 11'h4B4;
      5'h19:   bvs_lut = 11'h4CC;
      5'h1A:   bvs_lut = 11'h500;
      5'h1B:   bvs_lut = 11'h533;
      5'h1C:   bvs_lut = 11'h566;
      5'h1D:   bvs_lut = 11'h59A;
      5'h1E:   bvs_lut = 11'h5CC;
      default: bvs_lut = 11'h600;
    endcase
  endfunction : bvs_lut

  logic [15:0] div_ff;
  logic        tick;
  bvs_dac_t    target_ff;
  bvs_dac_t    ramp_ff;

  assign tick   = (div_ff == 16'(`BVS_SLEW_CYC - 1));
  assign target = target_ff;
  assign ramp   = ramp_ff;

  // ========================================================
  // slew divider
  always_ff @(posedge clk) begin
    if (sys_rst || tick) begin
      div_ff <= 16'h0000;
    end else begin
      div_ff <= div_ff + 16'h0001;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      target_ff <= 11'h000;
    end else begin
      target_ff <= bvs_lut(code);
    end
  end

  // ========================================================
  // ramp follows a target that may move mid soft-start
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ramp_ff <= 11'h000;
    end else if (ramp_en && tick) begin
      if (ramp_ff < target_ff) begin
        ramp_ff <= ramp_ff + 11'h001;
      end else if (ramp_ff > target_ff) begin
        ramp_ff <= ramp_ff - 11'h001;
      end
    end
  end

  ramp_up_a: assert property (@(posedge clk) disable iff (sys_rst)
    ramp_en && tick && ramp_ff < target_ff
    |=> ramp_ff == $past(ramp_ff) + 11'h001)
    else $error("ramp did not step up");

  ramp_down_a: assert property (@(posedge clk) disable iff (sys_rst)
    ramp_en && tick && ramp_ff > target_ff
    |=> ramp_ff == $past(ramp_ff) - 11'h001)
    else $error("ramp did not step down");

  lut_mid_a: assert property (@(posedge clk) disable iff (sys_rst)
    code == 5'h11 |=> target_ff == 11'h400)
    else $error("code 10001 not decoded");

endmodule : bvs_boot_dac

/* hw/bvs_boot_reg.sv */
`timescale 1ns/1ns
`include "bvs_map.svh"

module bvs_boot_reg
  import bvs_pkg::*;
(
  input  wire logic         clk,
  input  wire logic         sys_rst,
  input  wire logic         req_valid,
  input  bvs_req_s          req,
  output bvs_resp_s         resp,
  input  wire logic         nvm_load,
  input  wire logic [15:0]  nvm_word,
  input  wire logic         in_soft_start,
  input  wire logic         cml_clr,
  input  wire logic         ivd_clr,
  input  wire logic [7:0]   loop_gain,
  input  bvs_margin_e       margin_sel,
  input  bvs_dac_t          margin_high,
  input  bvs_dac_t          margin_low,
  input  wire logic [7:0]   trim,
  output logic              status_cml,
  output logic              status_ivd,
  output logic              restored,
  output bvs_dac_t          boot_dac_voltage,
  output bvs_dac_t          dac_ramp,
  output logic [15:0]       startup_vout
);

  typedef enum logic {ST_WAIT_NVM, ST_READY} bvs_load_e;

  // ========================================================
  // request decode
  logic        hit;
  logic        bad_wr;
  logic        good_wr;
  logic [15:0] word_ff;
  bvs_resp_s   resp_ff;
  logic        cml_ff;
  logic        ivd_ff;
  bvs_load_e   load_ff;
  logic        ramp_en;
  logic [15:0] vout_ff;

  assign hit     = req_valid && (req.code == `BVS_CMD_CODE);
  assign bad_wr  = hit && req.write &&
                   ((req.wdata & `BVS_RSVD_MASK) != 16'h0000);
  // no state gate at all: writes land during soft-start too
  assign good_wr = hit && req.write && !bad_wr;

  // ========================================================
  // register word
  // nvm restore beats a bus write landing in the same cycle
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      word_ff <= `BVS_WORD_RST;
    end else if (nvm_load) begin
      word_ff <= nvm_word & `BVS_WR_MASK;
    end else if (good_wr) begin
      word_ff <= req.wdata & `BVS_WR_MASK;
    end
  end

  // ========================================================
  // bus answer, one cycle after the request
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      resp_ff <= '0;
    end else begin
      resp_ff.valid <= hit;
      resp_ff.nack  <= bad_wr;
      if (hit && !req.write) begin
        resp_ff.rdata <= word_ff & `BVS_WR_MASK;
      end else begin
        resp_ff.rdata <= 16'h0000;
      end
    end
  end

  assign resp = resp_ff;

  // ========================================================
  // fault flags, set beats clear
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cml_ff <= 1'b0;
    end else if (bad_wr) begin
      cml_ff <= 1'b1;
    end else if (cml_clr) begin
      cml_ff <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ivd_ff <= 1'b0;
    end else if (bad_wr) begin
      ivd_ff <= 1'b1;
    end else if (ivd_clr) begin
      ivd_ff <= 1'b0;
    end
  end

  assign status_cml = cml_ff;
  assign status_ivd = ivd_ff;

  // ========================================================
  // restore sequencing
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      load_ff <= ST_WAIT_NVM;
    end else begin
      case (load_ff)
        ST_WAIT_NVM: begin
          if (nvm_load) begin
            load_ff <= ST_READY;
          end
        end
        ST_READY: load_ff <= ST_READY;
        default:  load_ff <= ST_WAIT_NVM;
      endcase
    end
  end

  assign restored = (load_ff == ST_READY);
  // soft-start held off until the restore has landed
  assign ramp_en  = in_soft_start && restored;

  // ========================================================
  // dac target and soft-start ramp
  bvs_boot_dac u_dac (
    .clk     (clk),
    .sys_rst (sys_rst),
    .code    (word_ff[`BVS_CODE_HI:`BVS_CODE_LO]),
    .ramp_en (ramp_en),
    .target  (boot_dac_voltage),
    .ramp    (dac_ramp)
  );

  // ========================================================
  // effective start-up voltage
  // margin replaces the target, trim is signed in dac lsb,
  // gain is the inverse of the loop divider; a wrong gain
  // from the host gives a wrong vout, nothing here checks it
  function automatic logic [15:0] bvs_vout(
    input bvs_dac_t    dac,
    input bvs_margin_e sel,
    input bvs_dac_t    hi,
    input bvs_dac_t    lo,
    input logic [7:0]  trm,
    input logic [7:0]  gain
  );
    logic signed [12:0] sum;
    logic        [11:0] pos;
    logic        [19:0] prod;
    case (sel)
      MRG_HIGH: sum = $signed({2'b00, hi});
      MRG_LOW:  sum = $signed({2'b00, lo});
      default:  sum = $signed({2'b00, dac});
    endcase
    sum  = sum + 13'($signed(trm));
    pos  = sum[12] ? 12'h000 : sum[11:0];
    prod = pos * gain;
    bvs_vout = {2'b00, prod[19:`BVS_GAIN_SHIFT]};
  endfunction : bvs_vout

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      vout_ff <= 16'h0000;
    end else begin
      vout_ff <= bvs_vout(boot_dac_voltage, margin_sel, margin_high,
                          margin_low, trim, loop_gain);
    end
  end

  assign startup_vout = vout_ff;

  // ========================================================
  // checks
  sequence bad_write_s;
    hit && req.write && ((req.wdata & `BVS_RSVD_MASK) != 16'h0000);
  endsequence

  sequence good_write_s;
    hit && req.write && ((req.wdata & `BVS_RSVD_MASK) == 16'h0000)
      && !nvm_load;
  endsequence

  rsvd_read_a: assert property (@(posedge clk) disable iff (sys_rst)
    resp_ff.valid |-> resp_ff.rdata[13:5] == 9'h000)
    else $error("reserved bits read nonzero");

  bad_keep_a: assert property (@(posedge clk) disable iff (sys_rst)
    bad_write_s ##0 !nvm_load |=> word_ff == $past(word_ff))
    else $error("refused write changed the word");

  bad_nack_a: assert property (@(posedge clk) disable iff (sys_rst)
    bad_write_s |=> resp_ff.valid && resp_ff.nack)
    else $error("refused write not nacked");

  bad_flags_a: assert property (@(posedge clk) disable iff (sys_rst)
    bad_write_s |=> status_cml && status_ivd)
    else $error("fault flags not set");

  good_store_a: assert property (@(posedge clk) disable iff (sys_rst)
    good_write_s |=> word_ff == ($past(req.wdata) & `BVS_WR_MASK)
      && !resp_ff.nack)
    else $error("valid write not stored");

  spare_keep_a: assert property (@(posedge clk) disable iff (sys_rst)
    good_write_s |=> word_ff[15:14] == $past(req.wdata[15:14]))
    else $error("spare bits not stored");

  code_track_a: assert property (@(posedge clk) disable iff (sys_rst)
    good_write_s ##1 !nvm_load && !good_wr
    |=> (boot_dac_voltage == 11'h400) == (word_ff[4:0] == 5'h11))
    else $error("dac target does not follow code");

  nvm_restore_a: assert property (@(posedge clk) disable iff (sys_rst)
    nvm_load |=> restored && word_ff[13:5] == 9'h000)
    else $error("restore wrong");

  no_ramp_a: assert property (@(posedge clk) disable iff (sys_rst)
    !restored |-> dac_ramp == 11'h000)
    else $error("ramp moved before restore");

  vout_unity_a: assert property (@(posedge clk) disable iff (sys_rst)
    margin_sel == MRG_NONE && trim == 8'h00 && loop_gain == 8'h40
    |=> vout_ff == {5'h00, $past(boot_dac_voltage)})
    else $error("unity startup voltage wrong");

endmodule : bvs_boot_reg

/* dv/bvs_host_model.sv */
`timescale 1ns/1ns

// ==========================================================
// host side: whole-word command transfers, one at a time
module bvs_host_model
  import bvs_pkg::*;
(
  input  wire logic clk,
  output logic      req_valid,
  output bvs_req_s  req,
  input  bvs_resp_s resp
);
  bvs_resp_s got;

  initial begin
    req_valid = 1'b0;
    req       = '0;
  end

  // request held from falling edge across the taking edge
  task automatic xfer(input logic wr, input logic [7:0] cd,
                      input logic [15:0] wd);
    @(negedge clk);
    req_valid = 1'b1;
    req       = '{write: wr, code: cd, wdata: wd};
    @(negedge clk);
    got       = resp;
    req_valid = 1'b0;
    // released lines show the inverse, not the last value
    req       = ~req;
  endtask : xfer
endmodule : bvs_host_model

/* dv/bvs_boot_reg_tb_top.sv */
`timescale 1ns/1ns

module bvs_boot_reg_tb_top
  import bvs_pkg::*;
;
  logic        clk, sys_rst, req_valid, nvm_load, in_ss, cml_clr, ivd_clr;
  logic        status_cml, status_ivd, restored;
  logic [15:0] nvm_word, startup_vout;
  logic [7:0]  loop_gain, trim;
  bvs_req_s    req;
  bvs_resp_s   resp;
  bvs_margin_e margin_sel;
  bvs_dac_t    margin_high, margin_low, bdv, ramp;
  int          n_fail, n_tests;

  bvs_host_model host (.clk(clk), .req_valid(req_valid), .req(req),
                       .resp(resp));
  bvs_boot_reg dut (.clk(clk), .sys_rst(sys_rst), .req_valid(req_valid),
    .req(req), .resp(resp), .nvm_load(nvm_load), .nvm_word(nvm_word),
    .in_soft_start(in_ss), .cml_clr(cml_clr), .ivd_clr(ivd_clr),
    .loop_gain(loop_gain), .margin_sel(margin_sel),
    .margin_high(margin_high), .margin_low(margin_low), .trim(trim),
    .status_cml(status_cml), .status_ivd(status_ivd), .restored(restored),
    .boot_dac_voltage(bdv), .dac_ramp(ramp), .startup_vout(startup_vout));

  always #5 clk = ~clk;

  task automatic chk(input string nm, input logic [15:0] s, e);
    n_tests++;
    if (s !== e) begin
      n_fail++;
      $display("[ERR] %s exp %h seen %h", nm, e, s);
    end
  endtask : chk

  task automatic results;
    if (n_fail == 0 && n_tests > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : results

  task automatic rd(input logic [15:0] e);
    host.xfer(1'b0, 8'hD5, 16'h0000);
    chk("rvalid", {15'h0000, host.got.valid}, 16'h0001);
    chk("rdata", host.got.rdata, e);
  endtask : rd

  task automatic wr(input logic [15:0] d, input logic nk);
    host.xfer(1'b1, 8'hD5, d);
    chk("wvalid", {15'h0000, host.got.valid}, 16'h0001);
    chk("nack", {15'h0000, host.got.nack}, {15'h0000, nk});
  endtask : wr

  task automatic wait_n(input int n);
    repeat (n) @(negedge clk);
  endtask : wait_n

  // ========================================================
  // scenarios
  task automatic t_reset;
    chk("restored", {15'h0000, restored}, 16'h0000);
    rd(16'h0000);
    // a live target before restore must not start the ramp
    in_ss = 1'b1;
    wr(16'h001F, 1'b0);
    wait_n(150);
    chk("ramp_hold", {5'h00, ramp}, 16'h0000);
    in_ss = 1'b0;
    nvm_word = 16'hFFFF;
    nvm_load = 1'b1;
    wait_n(1);
    nvm_load = 1'b0;
    chk("restored", {15'h0000, restored}, 16'h0001);
    rd(16'hC01F);
  endtask : t_reset

  task automatic t_codes;
    logic [4:0]  cd [4] = '{5'h03, 5'h11, 5'h1F, 5'h00};
    logic [15:0] ev [4] = '{16'h029A, 16'h0400, 16'h0600, 16'h0000};
    wr(16'hC011, 1'b0);
    rd(16'hC011);
    for (int i = 0; i < 4; i++) begin
      wr({11'h000, cd[i]}, 1'b0);
      wait_n(1);
      chk("dac", {5'h00, bdv}, ev[i]);
    end
  endtask : t_codes

  task automatic t_bad;
    logic [15:0] bad [2] = '{16'hC03F, 16'h6001};
    for (int i = 0; i < 2; i++) begin
      wr(bad[i], 1'b1);
      wait_n(1);
      chk("cml", {15'h0000, status_cml}, 16'h0001);
      chk("ivd", {15'h0000, status_ivd}, 16'h0001);
      rd(16'h0000);
      cml_clr = 1'b1;
      wait_n(1);
      cml_clr = 1'b0;
      chk("cml_clr", {14'h0000, status_cml, status_ivd}, 16'h0001);
      ivd_clr = 1'b1;
      wait_n(1);
      ivd_clr = 1'b0;
      chk("ivd_clr", {14'h0000, status_cml, status_ivd}, 16'h0000);
    end
    // foreign command code gets no answer and no effect
    host.xfer(1'b1, 8'hD4, 16'h0001);
    chk("other", {15'h0000, host.got.valid}, 16'h0000);
    rd(16'h0000);
  endtask : t_bad

  task automatic t_ramp;
    in_ss = 1'b1;
    wr(16'h0003, 1'b0);
    wait_n(1000);
    // counter phase unknown, so a window of one step either side
    chk("ramp_up", {15'h0000, ramp >= 9 && ramp <= 11}, 16'h0001);
    wr(16'h0000, 1'b0);
    wait_n(500);
    chk("ramp_dn", {15'h0000, ramp >= 4 && ramp <= 6}, 16'h0001);
    in_ss = 1'b0;
  endtask : t_ramp

  task automatic t_vout;
    wr(16'h001F, 1'b0);
    wait_n(3);
    chk("vout", startup_vout, 16'h0600);
    margin_sel  = MRG_HIGH;
    margin_high = 11'h3E8;
    trim        = 8'h08;
    loop_gain   = 8'h80;
    wait_n(3);
    chk("vout_hi", startup_vout, 16'h07E0);
    margin_sel  = MRG_LOW;
    margin_low  = 11'h004;
    trim        = 8'hF8;
    wait_n(3);
    chk("vout_lo", startup_vout, 16'h0000);
  endtask : t_vout

  initial begin
    clk = 1'b0; sys_rst = 1'b1; nvm_load = 1'b0; nvm_word = 16'h0000;
    in_ss = 1'b0; cml_clr = 1'b0; ivd_clr = 1'b0; loop_gain = 8'h40;
    margin_sel = MRG_NONE; margin_high = '0; margin_low = '0;
    trim = 8'h00; n_fail = 0; n_tests = 0;
    wait_n(5);
    sys_rst = 1'b0;
    t_reset();
    t_codes();
    t_bad();
    t_ramp();
    t_vout();
    results();
  end

  // whole run is near 1700 cycles
  initial begin
    #200000;
    n_fail++;
    results();
  end
endmodule : bvs_boot_reg_tb_top
